// ==== rtl/touch_adc_i2c_slave_sequencer.sv ====
// i2c slave front end and command sequencer of a resistive touch controller
//
// Contract
// - address is prefix, then select-pin bit, then fixed zero bit.
// - last address bit: one reads the result, zero writes a command.
// - acknowledge an address only when every field matches.
// - codes 8,9,a switch drivers only; b reserved; 7 selects sleep.
// - codes c-f route one panel input to the converter with drivers.
// - power-down field sets converter and pen state after the command.
// - mode bit zero gives twelve bits, one gives eight; ignore don't-cares.
// - write: address, ack, one command byte, ack, then stop or start.
// - bytes after the first command byte get no acknowledge.
// - channel selected after four config bits; drivers on at acquisition.
// - acquisition from scl fall after last config bit until stop/start.
// - conversion disconnects the mux but keeps position drivers on.
// - read sends upper eight result bits first, msb first.
// - after master ack send lower four bits then four zeros.
// - master nack ends read; ack repeats the byte pair.
// - results are unsigned straight binary.
// - eight-bit mode drops four decisions; one byte holds the result.
// - sleep code opens panel; pen pin floats or drives high by mode; code enters sleep only when pd0 is 0.
// - write address ack disables pen; re-enabled at conversion end unless power-down field is 3; a conversion ending in the ack cycle wins.
`timescale 1ns/100ps
module touch_adc_i2c_slave_sequencer
	import touch_pkg::*;
#(
	parameter logic [4:0] PREFIX = DEF_PREFIX,
	parameter int         TICK   = BIT_CYCLES
) (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              scl_in,
	input  wire logic              sda_in,
	output logic                   sda_out,
	output logic                   sda_oe,
	input  wire logic              addr_select_pin,
	input  wire logic              pen_touch_detect,
	input  wire logic              cmp_hi,
	output logic                   x_pos_drv,
	output logic                   x_neg_drv,
	output logic                   y_pos_drv,
	output logic                   y_neg_drv,
	output mux_sel_t               mux_sel,
	output logic                   mux_connect,
	output logic [RES_BITS-1:0]    dac_code,
	output logic                   adc_power,
	output logic                   conv_busy,
	output logic                   sleep_mode,
	output logic                   pen_touch_irq_n_out,
	output logic                   pen_touch_irq_n_oe
);

	generate
		if (TICK < 1) begin : g_bad
			$error("touch controller: TICK must be at least one");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	function automatic logic [3:0] drivers_of(input logic [3:0] c);
		// order is x+, x-, y+, y-
		case (c)
			CF_DRV_X, CF_MEAS_X:               drivers_of = 4'hc;
			CF_DRV_Y, CF_MEAS_Y:               drivers_of = 4'h3;
			CF_DRV_YX, CF_MEAS_Z1, CF_MEAS_Z2: drivers_of = 4'h6;
			default:                           drivers_of = 4'h0;
		endcase
	endfunction

	function automatic mux_sel_t mux_of(input logic [3:0] c);
		case (c)
			CF_MEAS_X:  mux_of = MUX_YP;
			CF_MEAS_Y:  mux_of = MUX_XP;
			CF_MEAS_Z1: mux_of = MUX_XP;
			CF_MEAS_Z2: mux_of = MUX_YN;
			default:    mux_of = MUX_NONE;
		endcase
	endfunction

	function automatic logic is_meas(input logic [3:0] c);
		is_meas = (c[3:2] == 2'h3);
	endfunction

	function automatic logic is_drv_only(input logic [3:0] c);
		is_drv_only = (c == CF_DRV_X) || (c == CF_DRV_Y) || (c == CF_DRV_YX);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers: stage one feeds stage two only
	logic [1:0] scl_sy, sda_sy, sel_sy, pen_sy, cmp_sy;
	logic       scl_d, sda_d;

	always_ff @(posedge clk) begin
		if (rst) begin
			scl_sy <= 2'h3;
			sda_sy <= 2'h3;
			sel_sy <= 2'h0;
			pen_sy <= 2'h0;
			cmp_sy <= 2'h0;
			scl_d  <= 1'b1;
			sda_d  <= 1'b1;
		end else begin
			scl_sy <= {scl_sy[0], scl_in};
			sda_sy <= {sda_sy[0], sda_in};
			sel_sy <= {sel_sy[0], addr_select_pin};
			pen_sy <= {pen_sy[0], pen_touch_detect};
			cmp_sy <= {cmp_sy[0], cmp_hi};
			scl_d  <= scl_sy[1];
			sda_d  <= sda_sy[1];
		end
	end

	logic scl_rise, scl_fall, bus_start, bus_stop, bus_end;
	assign scl_rise  = scl_sy[1] && !scl_d;
	assign scl_fall  = !scl_sy[1] && scl_d;
	assign bus_start = scl_sy[1] && scl_d && sda_d && !sda_sy[1];
	assign bus_stop  = scl_sy[1] && scl_d && !sda_d && sda_sy[1];
	assign bus_end   = bus_start || bus_stop;

	////////////////////////////////////////////////////////////////////////////
	// serial engine
	i2c_st_t                state_q;
	logic [3:0]             cnt_q;
	logic [7:0]             sr_q;
	logic [7:0]             tx_q;
	logic                   byte_sel_q;
	logic                   ack_q;
	logic                   cmd_new_q;
	logic [7:0]             cmd_q;
	logic [3:0]             code_q;
	logic [RES_BITS-1:0]    result;
	logic                   addr_match, byte_end, addr_wr_ack, acq_begin;

	assign addr_match  = (sr_q[7:3] == PREFIX) && (sr_q[2] == sel_sy[1])
		&& (sr_q[1] == ADDR_FIXED);
	assign byte_end    = scl_fall && (cnt_q == BYTE_LAST);
	assign addr_wr_ack = (state_q == ST_ADDR) && byte_end && addr_match
		&& (sr_q[0] != DIR_READ);
	assign acq_begin   = (state_q == ST_CMD) && scl_fall && (cnt_q == CF_DONE)
		&& is_meas(code_q);

	function automatic logic [7:0] tx_byte(input logic sel, input logic [11:0] r);
		tx_byte = sel ? {r[3:0], PAD_ZERO} : r[11:4];
	endfunction

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q    <= ST_IDLE;
			cnt_q      <= '0;
			sr_q       <= '0;
			tx_q       <= '0;
			byte_sel_q <= 1'b0;
			ack_q      <= 1'b0;
		end else if (bus_start) begin
			state_q <= ST_ADDR;
			cnt_q   <= '0;
		end else if (bus_stop) begin
			state_q <= ST_IDLE;
		end else begin
			if (scl_rise) begin
				sr_q  <= {sr_q[6:0], sda_sy[1]};
				ack_q <= !sda_sy[1];
			end
			case (state_q)
				ST_ADDR, ST_CMD: begin
					if (scl_rise) begin
						cnt_q <= cnt_q + 4'h1;
					end
					if (byte_end && state_q == ST_ADDR) begin
						state_q <= addr_match ? ST_ADDR_ACK : ST_IDLE;
					end else if (byte_end) begin
						state_q <= ST_CMD_ACK;
					end
				end
				ST_ADDR_ACK: begin
					if (scl_fall) begin
						cnt_q <= '0;
						// ack bit already shifted in on the rise, direction sits one up
						if (sr_q[1] == DIR_READ) begin
							state_q    <= ST_TX;
							byte_sel_q <= 1'b0;
							tx_q       <= tx_byte(1'b0, result);
						end else begin
							state_q <= ST_CMD;
						end
					end
				end
				ST_CMD_ACK: begin
					if (scl_fall) begin
						state_q <= ST_SKIP;
					end
				end
				ST_TX: begin
					if (scl_fall && cnt_q == 4'h7) begin
						state_q <= ST_TX_ACK;
					end else if (scl_fall) begin
						tx_q  <= {tx_q[6:0], 1'b0};
						cnt_q <= cnt_q + 4'h1;
					end
				end
				ST_TX_ACK: begin
					if (scl_fall && ack_q) begin
						state_q    <= ST_TX;
						cnt_q      <= '0;
						byte_sel_q <= !byte_sel_q;
						tx_q       <= tx_byte(!byte_sel_q, result);
					end else if (scl_fall) begin
						state_q <= ST_IDLE;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// command capture; code is known after four bits
	always_ff @(posedge clk) begin
		if (rst) begin
			cmd_q     <= CMD_RESET;
			code_q    <= CMD_RESET[CF_HI:CF_LO];
			cmd_new_q <= 1'b0;
			mux_sel   <= MUX_NONE;
		end else begin
			if (state_q == ST_CMD && scl_rise && cnt_q == 4'h3) begin
				code_q  <= {sr_q[2:0], sda_sy[1]};
				mux_sel <= mux_of({sr_q[2:0], sda_sy[1]});
			end
			if (state_q == ST_CMD && byte_end) begin
				cmd_q     <= sr_q;
				cmd_new_q <= 1'b1;
			end else if (bus_end) begin
				cmd_new_q <= 1'b0;
			end
		end
	end

	// open-drain data pin, registered
	always_ff @(posedge clk) begin
		if (rst) begin
			sda_oe <= 1'b0;
		end else begin
			sda_oe <= (state_q == ST_ADDR_ACK) || (state_q == ST_CMD_ACK)
				|| (state_q == ST_TX && !tx_q[7]);
		end
	end
	assign sda_out = 1'b0;

	////////////////////////////////////////////////////////////////////////////
	// acquisition, conversion and power state
	phase_t     phase_q;
	logic [3:0] drv_q;
	logic       pen_en_q, forced_low_q, sleep_m_q, sar_start, sar_done;
	logic       pd0, mode_short;

	assign pd0        = cmd_q[PD0_POS];
	assign mode_short = cmd_q[MODE_POS];
	assign sar_start  = (phase_q == PH_ACQ) && bus_end;

	always_ff @(posedge clk) begin
		if (rst) begin
			phase_q      <= PH_IDLE;
			drv_q        <= '0;
			pen_en_q     <= 1'b1;
			forced_low_q <= 1'b0;
			adc_power    <= 1'b0;
			sleep_mode   <= 1'b0;
			sleep_m_q    <= 1'b0;
		end else begin
			if (addr_wr_ack) begin
				pen_en_q <= 1'b0;
			end
			if (acq_begin) begin
				phase_q <= PH_ACQ;
				drv_q   <= drivers_of(code_q);
			end else if (sar_start) begin
				phase_q   <= PH_CONV;
				adc_power <= 1'b1;
			end else if (sar_done) begin
				phase_q   <= PH_IDLE;
				adc_power <= pd0;
				pen_en_q  <= (cmd_q[PD1_POS:PD0_POS] != PD_NO_PEN);
				if (!pd0) begin
					drv_q <= '0;
				end
			end else if (bus_end && cmd_new_q && !is_meas(code_q)) begin
				drv_q        <= drivers_of(code_q);
				forced_low_q <= is_drv_only(code_q);
				sleep_mode   <= (code_q == CF_SLEEP) && !pd0;
				sleep_m_q    <= mode_short;
				adc_power    <= pd0;
				pen_en_q     <= (cmd_q[PD1_POS:PD0_POS] != PD_NO_PEN);
			end
			if (acq_begin) begin
				forced_low_q <= 1'b0;
				sleep_mode   <= 1'b0;
			end
		end
	end

	assign {x_pos_drv, x_neg_drv, y_pos_drv, y_neg_drv} = drv_q;
	assign mux_connect = (phase_q == PH_ACQ);

	sar_sequencer #(
		.BITS       (RES_BITS),
		.DROP       (SHORT_DROP),
		.TICK       (TICK)
	) u_sar (
		.clk        (clk),
		.rst        (rst),
		.start      (sar_start),
		.short_mode (mode_short),
		.cmp_hi     (cmp_sy[1]),
		.dac_code   (dac_code),
		.busy       (conv_busy),
		.done       (sar_done),
		.result     (result)
	);

	// pen pin: sleep, forced low, live touch, or parked high
	always_ff @(posedge clk) begin
		if (rst) begin
			pen_touch_irq_n_out <= 1'b1;
			pen_touch_irq_n_oe  <= 1'b1;
		end else if (sleep_mode) begin
			pen_touch_irq_n_out <= 1'b1;
			pen_touch_irq_n_oe  <= !sleep_m_q;
		end else if (forced_low_q) begin
			pen_touch_irq_n_out <= 1'b0;
			pen_touch_irq_n_oe  <= 1'b1;
		end else begin
			pen_touch_irq_n_out <= !(pen_en_q && pen_sy[1] && phase_q == PH_IDLE);
			pen_touch_irq_n_oe  <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	a_addr_mismatch: assert property ((state_q == ST_ADDR) && byte_end && !addr_match
		&& !bus_end |=> state_q == ST_IDLE) else $error("bad address acknowledged");
	a_addr_ack_drive: assert property ($rose(state_q == ST_ADDR_ACK) |=> sda_oe)
		else $error("no ack on matching address");
	a_extra_nack: assert property ((state_q == ST_SKIP)[*2] |-> !sda_oe)
		else $error("extra command byte acknowledged");
	a_acq_start: assert property (acq_begin && !bus_end |=> phase_q == PH_ACQ && mux_connect)
		else $error("acquisition did not begin");
	a_conv_mux_off: assert property (sar_start |=> phase_q == PH_CONV && !mux_connect
		&& drv_q == $past(drv_q)) else $error("conversion kept mux or lost drivers");
	a_first_upper: assert property ($rose(state_q == ST_TX) && !byte_sel_q
		|-> tx_q == result[11:4]) else $error("first byte not upper bits");
	a_pair_repeat: assert property ((state_q == ST_TX_ACK) && scl_fall && ack_q && !bus_end
		|=> state_q == ST_TX && byte_sel_q != $past(byte_sel_q))
		else $error("byte pair not repeated");
	a_low_pad: assert property ((state_q == ST_TX_ACK) && scl_fall && ack_q && !byte_sel_q
		&& !bus_end |=> tx_q[3:0] == PAD_ZERO) else $error("second byte not padded");
	a_pen_off_write: assert property (addr_wr_ack && !sar_done |=> !pen_en_q)
		else $error("pen left enabled on write");
	a_sleep_float: assert property ((sleep_mode && sleep_m_q)[*2] |-> !pen_touch_irq_n_oe)
		else $error("pen pin driven in sleep");

	c_write_conv: cover property (sar_start ##[1:300] sar_done);
	c_read_pair: cover property ((state_q == ST_TX_ACK) && scl_fall && ack_q);
	c_extra_byte: cover property (state_q == ST_SKIP && scl_fall);
	c_sleep: cover property ($rose(sleep_mode));

endmodule

// ==== include/touch_pkg.sv ====
// shared constants and types for the touch screen controller front end
package touch_pkg;

	localparam int          CLK_MHZ     = 25;
	localparam int          BIT_NS      = 800;
	// least time per bit decision, rounded up to whole cycles
	localparam int          BIT_CYCLES  = (BIT_NS * CLK_MHZ + 999) / 1000;
	localparam int          RES_BITS    = 12;
	localparam int          SHORT_DROP  = 4;

	// device-type prefix; value is arbitrary
	localparam logic [4:0]  DEF_PREFIX  = 5'h0b;
	localparam logic        ADDR_FIXED  = 1'h0;
	localparam logic        DIR_READ    = 1'h1;

	// command byte layout
	localparam int          CF_HI       = 7;
	localparam int          CF_LO       = 4;
	localparam int          PD1_POS     = 3;
	localparam int          PD0_POS     = 2;
	localparam int          MODE_POS    = 1;
	localparam logic [7:0]  CMD_RESET   = 8'h00;

	localparam logic [3:0]  CF_SLEEP    = 4'h7;
	localparam logic [3:0]  CF_DRV_X    = 4'h8;
	localparam logic [3:0]  CF_DRV_Y    = 4'h9;
	localparam logic [3:0]  CF_DRV_YX   = 4'ha;
	localparam logic [3:0]  CF_MEAS_X   = 4'hc;
	localparam logic [3:0]  CF_MEAS_Y   = 4'hd;
	localparam logic [3:0]  CF_MEAS_Z1  = 4'he;
	localparam logic [3:0]  CF_MEAS_Z2  = 4'hf;

	localparam logic [1:0]  PD_NO_PEN   = 2'h3;
	localparam logic [3:0]  PAD_ZERO    = 4'h0;
	localparam logic [3:0]  BYTE_LAST   = 4'h8;
	localparam logic [3:0]  CF_DONE     = 4'h4;

	typedef enum logic [1:0] {MUX_YP, MUX_XP, MUX_YN, MUX_NONE} mux_sel_t;
	typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK,
		ST_SKIP, ST_TX, ST_TX_ACK} i2c_st_t;
	typedef enum logic [1:0] {PH_IDLE, PH_ACQ, PH_CONV} phase_t;

endpackage

// ==== rtl/sar_sequencer.sv ====
// successive-approximation bit sequencer with result holding register
`timescale 1ns/100ps
module sar_sequencer
	import touch_pkg::*;
#(
	parameter int BITS = RES_BITS,
	parameter int DROP = SHORT_DROP,
	parameter int TICK = BIT_CYCLES
) (
	input  wire logic            clk,
	input  wire logic            rst,
	input  wire logic            start,
	input  wire logic            short_mode,
	input  wire logic            cmp_hi,
	output logic [BITS-1:0]      dac_code,
	output logic                 busy,
	output logic                 done,
	output logic [BITS-1:0]      result
);

	localparam int TW = $clog2(TICK + 1);
	localparam int IW = $clog2(BITS);

	generate
		if (TICK < 1 || DROP >= BITS || BITS < 2) begin : g_bad
			$error("sar_sequencer: unusable parameters");
		end
	endgenerate

	logic [TW-1:0]   tick_q;
	logic [IW-1:0]   idx_q;
	logic [BITS-1:0] trial_q;
	logic [IW-1:0]   last_idx;
	logic            tick;

	// short mode stops four decisions early, low bits stay zero
	assign last_idx = short_mode ? IW'(DROP) : '0;
	assign tick     = busy && (tick_q == TW'(TICK - 1));
	assign dac_code = trial_q;

	always_ff @(posedge clk) begin
		if (rst || !busy || tick) begin
			tick_q <= '0;
		end else begin
			tick_q <= tick_q + TW'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			busy    <= 1'b0;
			done    <= 1'b0;
			idx_q   <= '0;
			trial_q <= '0;
		end else begin
			done <= 1'b0;
			if (start) begin
				busy    <= 1'b1;
				idx_q   <= IW'(BITS - 1);
				trial_q <= {1'b1, {(BITS-1){1'b0}}};
			end else if (tick) begin
				// keep the trial bit when the input sits above it
				trial_q[idx_q] <= cmp_hi;
				if (idx_q == last_idx) begin
					busy <= 1'b0;
					done <= 1'b1;
				end else begin
					idx_q              <= idx_q - IW'(1);
					trial_q[idx_q-IW'(1)] <= 1'b1;
				end
			end
		end
	end

	// holding register changes only once a conversion is complete
	always_ff @(posedge clk) begin
		if (rst) begin
			result <= '0;
		end else if (done) begin
			result <= trial_q;
		end
	end

endmodule

// ==== tb/i2c_host_model.sv ====
// i2c bus master model that drives scl and pulls sda low
`timescale 1ns/100ps
module i2c_host_model (
	input  wire logic clk,
	input  wire logic sda_line,
	output logic      scl,
	output logic      sda_low
);
	initial begin
		scl = 1'h1;
		sda_low = 1'h0;
	end

	task automatic tk(input int n);
		repeat (n) @(posedge clk);
	endtask

	////////////////////////////////////////////////////////////////
	// also a repeated start; scl stands high between frames
	task automatic start_c;
		sda_low <= 1'h0;
		tk(2);
		scl <= 1'h1;
		tk(4);
		sda_low <= 1'h1;
		tk(4);
		scl <= 1'h0;
		tk(2);
	endtask

	task automatic stop_c;
		sda_low <= 1'h1;
		tk(2);
		scl <= 1'h1;
		tk(4);
		sda_low <= 1'h0;
		tk(4);
	endtask

	// sda moves only while scl is low; sampled late in the high phase
	task automatic bit_io(input logic b, output logic got);
		sda_low <= ~b;
		tk(2);
		scl <= 1'h1;
		tk(3);
		got = sda_line;
		tk(1);
		scl <= 1'h0;
		tk(2);
	endtask

	task automatic wr_byte(input logic [7:0] b, output logic ack);
		logic g;
		for (int i = 7; i >= 0; i--) bit_io(b[i], g);
		bit_io(1'h1, g);
		ack = ~g;
	endtask

	task automatic rd_byte(input logic mack, output logic [7:0] b);
		logic g;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'h1, g);
			b[i] = g;
		end
		bit_io(~mack, g);
	endtask
endmodule

// ==== tb/touch_adc_i2c_slave_sequencer_tb.sv ====
// self-checking bench for the touch controller i2c front end
`timescale 1ns/100ps
module touch_adc_i2c_slave_sequencer_tb;
	import touch_pkg::*;
	localparam int TK = 4;
	logic                clk, rst, scl, sda_low, sda_line, sel, touch, cmp_hi;
	logic                sda_out, sda_oe, xp, xn, yp, yn, mux_connect;
	logic                adc_power, conv_busy, sleep_mode, pen_out, pen_oe;
	mux_sel_t            mux_sel;
	logic [RES_BITS-1:0] dac_code, vin;
	int                  failures, num_checks;

	// open drain with pull-up
	assign sda_line = ~(sda_low | (sda_oe & ~sda_out));
	always @(posedge clk) cmp_hi <= (vin >= dac_code);
	initial begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end

	touch_adc_i2c_slave_sequencer #(.TICK(TK)) uut (
		.clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda_line),
		.sda_out(sda_out), .sda_oe(sda_oe), .addr_select_pin(sel),
		.pen_touch_detect(touch), .cmp_hi(cmp_hi), .x_pos_drv(xp),
		.x_neg_drv(xn), .y_pos_drv(yp), .y_neg_drv(yn), .mux_sel(mux_sel),
		.mux_connect(mux_connect), .dac_code(dac_code), .adc_power(adc_power),
		.conv_busy(conv_busy), .sleep_mode(sleep_mode),
		.pen_touch_irq_n_out(pen_out), .pen_touch_irq_n_oe(pen_oe));
	i2c_host_model host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));

	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic stop_test;
		$display("checks=%0d failures=%0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	task automatic step(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	function automatic logic [7:0] addr(input logic rw);
		return {DEF_PREFIX, sel, ADDR_FIXED, rw};
	endfunction

	task automatic wr_cmd(input logic [7:0] cmd);
		logic a;
		host.start_c();
		host.wr_byte(addr(1'h0), a);
		chk(12'(a), 12'h1);
		host.wr_byte(cmd, a);
		chk(12'(a), 12'h1);
	endtask

	////////////////////////////////////////////////////////////////
	task automatic t_bad;
		logic a;
		logic [7:0] bad [3];
		bad = '{{DEF_PREFIX ^ 5'h01, sel, 2'h0}, {DEF_PREFIX, ~sel, 2'h0},
			{DEF_PREFIX, sel, 2'h2}};
		for (int i = 0; i < 3; i++) begin
			host.start_c();
			host.wr_byte(bad[i], a);
			chk(12'(a), 12'h0);
			host.stop_c();
		end
	endtask

	task automatic t_meas(input logic [3:0] cf, input logic [1:0] pd, input logic m,
		input logic [11:0] v, input mux_sel_t emux, input logic [3:0] edrv);
		logic a;
		logic [7:0] b0;
		logic [11:0] r;
		int n;
		vin <= v;
		r = m ? {v[11:4], 4'h0} : v;
		wr_cmd({cf, pd, m, 1'h1});
		chk(12'(mux_sel), 12'(emux));
		chk(12'({xp, xn, yp, yn}), 12'(edrv));
		chk(12'({mux_connect, pen_out}), 12'h3);
		host.wr_byte(8'h5a, a);
		chk(12'(a), 12'h0);
		host.stop_c();
		step(1);
		chk(12'({mux_connect, conv_busy}), 12'h1);
		chk(12'({xp, xn, yp, yn}), 12'(edrv));
		n = 0;
		while (conv_busy === 1'h1 && n < 300) begin
			step(1);
			n++;
		end
		step(2);
		n = (m ? 8 : 12) * TK - n;
		chk(12'(n >= -1 && n <= 6), 12'h1);
		chk(12'(adc_power), 12'(pd[0]));
		chk(12'({xp, xn, yp, yn}), pd[0] ? 12'(edrv) : 12'h0);
		chk(12'(pen_out), 12'(pd == PD_NO_PEN));
		step(200); // idle before reading the result back
		host.start_c();
		host.wr_byte(addr(1'h1), a);
		chk(12'(a), 12'h1);
		for (int i = 0; i < 4; i++) begin
			host.rd_byte(i < 3, b0);
			chk(12'(b0), i[0] ? {4'h0, r[3:0], 4'h0} : 12'(r[11:4]));
		end
		host.stop_c();
	endtask

	task automatic t_drv(input logic [3:0] cf, input logic [3:0] edrv);
		wr_cmd({cf, 4'h0});
		host.stop_c();
		step(4);
		chk(12'({xp, xn, yp, yn, conv_busy}), 12'({edrv, 1'h0}));
		if (cf != 4'hb) chk(12'({pen_out, pen_oe}), 12'h1);
	endtask

	task automatic t_sleep(input logic m);
		wr_cmd({CF_SLEEP, 1'h1, 1'h0, m, 1'h0});
		host.stop_c();
		step(4);
		chk(12'({sleep_mode, xp, xn, yp, yn, pen_oe}), 12'({5'h10, ~m}));
		if (!m) chk(12'(pen_out), 12'h1);
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		repeat (60000) @(posedge clk);
		failures++;
		stop_test();
	end

	initial begin
		rst = 1'h1;
		sel = 1'h1;
		touch = 1'h1;
		vin = 12'h0;
		failures = 0;
		num_checks = 0;
		repeat (4) @(posedge clk);
		rst <= 1'h0;
		step(4);
		// pen enabled from reset and panel touched, so the pin is pulled low
		chk(12'({sda_oe, conv_busy, adc_power, pen_out, pen_oe}), 12'h1);
		chk(12'(mux_sel), 12'(MUX_NONE));
		t_bad();
		t_meas(CF_MEAS_X, 2'h0, 1'h0, 12'ha5c, MUX_YP, 4'hc);
		t_meas(CF_MEAS_Y, 2'h1, 1'h1, 12'h3e1, MUX_XP, 4'h3);
		t_meas(CF_MEAS_Z1, 2'h3, 1'h0, 12'h7f0, MUX_XP, 4'h6);
		t_meas(CF_MEAS_Z2, 2'h2, 1'h1, 12'h18b, MUX_YN, 4'h6);
		sel <= 1'h0;
		t_drv(CF_DRV_X, 4'hc);
		t_drv(CF_DRV_Y, 4'h3);
		t_drv(CF_DRV_YX, 4'h6);
		t_drv(4'hb, 4'h0);
		t_sleep(1'h0);
		t_sleep(1'h1);
		stop_test();
	end
endmodule
